// File: rtl/wdt_config_readback.sv
// Windowed watchdog control, window check and register readback over APB
//
// Functional notes
// RULE_01 - Clock source field bits 6:4; 000 low, 001 medium oscillator, rest reserved
// RULE_02 - Window field bits 2:0; 111 fully open, each lower code closes 12.5%
// RULE_03 - Config clock source 111 resets clock source field to 000
// RULE_04 - Window field reset value comes from config window field
// RULE_05 - Config clock source not 111 makes clock source field read-only
// RULE_06 - Config window not 111 makes window field read-only
// RULE_07 - 18-bit prescale count readable across three registers, zero after reset
// RULE_08 - Firmware uses prescale readback for debug only
// RULE_09 - Watchdog counter value readable at timer register bits 6:3
// RULE_10 - Armed state readable at timer register bit 2
// RULE_11 - Unimplemented bits read zero
// RULE_12 - Clear while window closed is a violation and requests reset
// RULE_13 - Windowed clear needs arming by control zero read first
// RULE_14 - Write to either control register clears the counter
// RULE_15 - Active window from config field unless 111, then register field
// RULE_16 - Armed state drops whenever the counter is cleared; here a control zero read in the same cycle sets it instead
// RULE_17 - Active window 111 never gives a violation
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module wdt_config_readback
    import wdt_pkg::*;
(
    input  wire logic         mclk,        // System clock, 100 MHz
    input  wire logic         nrst,        // Async reset, active low
    input  wire cfg_word_type cfgWord,     // Configuration word fields
    input  wire logic         sleepMode,   // Device is asleep
    input  wire logic         clearReq,    // Clear instruction pulse
    input  wire logic         psel,        // APB select
    input  wire logic         penable,     // APB enable
    input  wire logic         pwrite,      // APB direction
    input  wire logic [7:0]   paddr,       // APB byte address
    input  wire logic [31:0]  pwdata,      // APB write data
    output logic              pready,      // APB ready
    output logic      [31:0]  prdata,      // APB read data
    output logic              pslverr,     // APB error
    output logic              resetReq,    // Watchdog reset pulse
    output logic              spanViolate, // Window violation pulse
    output logic              irq          // Interrupt level
);
    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic setupPhase;
    logic accessPhase;
    logic wrAcc;
    logic rdAcc;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a <= OFS_EVT_CLR) && (a[1:0] == 2'b00);
    endfunction

    assign setupPhase  = psel && !penable;
    assign accessPhase = psel && penable;
    assign wrAcc       = accessPhase && pwrite && mapped(paddr);
    assign rdAcc       = accessPhase && !pwrite && mapped(paddr);
    assign pready      = accessPhase;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic       loaded_reg;
    logic       swEnable_reg;
    logic [4:0] period_reg;
    logic [2:0] source_reg;
    logic [2:0] span_reg;
    logic       srcFree;
    logic       spanFree;
    logic       periodFree;
    logic [2:0] srcUsed;
    logic [2:0] spanUsed;
    logic [4:0] periodUsed;

    assign srcFree    = (cfgWord.clockSource == CODE_FREE);
    assign spanFree   = (cfgWord.openSpan == CODE_FREE);
    assign periodFree = (cfgWord.period == PERIOD_FREE);
    assign srcUsed    = srcFree ? source_reg : cfgWord.clockSource;
    assign spanUsed   = spanFree ? span_reg : cfgWord.openSpan;             // RULE_15
    assign periodUsed = periodFree ? period_reg : cfgWord.period;

    // Configuration straps are caught on the first edge after reset release
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            loaded_reg   <= 1'b0;
            swEnable_reg <= 1'b0;
            period_reg   <= PERIOD_DEFAULT;
            source_reg   <= SRC_LF;
            span_reg     <= CODE_FREE;
        end else if (!loaded_reg) begin
            loaded_reg <= 1'b1;
            period_reg <= periodFree ? PERIOD_DEFAULT : cfgWord.period;
            source_reg <= SRC_LF;                                           // RULE_03
            span_reg   <= cfgWord.openSpan;                                 // RULE_04
        end else if (wrAcc && paddr == OFS_CTRL0) begin
            swEnable_reg <= pwdata[SWEN_POS];
            if (periodFree) begin
                period_reg <= pwdata[PERIOD_POS +: 5];
            end
        end else if (wrAcc && paddr == OFS_CTRL1) begin
            if (srcFree) begin
                source_reg <= pwdata[SRC_POS +: 3];                         // RULE_05
            end
            if (spanFree) begin
                span_reg <= pwdata[SPAN_POS +: 3];                          // RULE_06
            end
        end
    end

    // ------------------------------------------------------------
    // Time base and counter
    // ------------------------------------------------------------
    logic             lfTick;
    logic             mfTick;
    logic             tick;
    logic             active;
    logic             cntClear;
    logic             ctrlWrite;
    logic [TOT_W-1:0] count;
    logic             timeout;
    logic             armed_reg;
    logic             windowed;
    logic             closed;
    logic             violation;
    logic             validClear;

    tick_divider #(.DIV(LF_TICK_CYCLES)) lfDiv (
        .mclk (mclk),
        .nrst (nrst),
        .tick (lfTick)
    );

    tick_divider #(.DIV(MF_TICK_CYCLES)) mfDiv (
        .mclk (mclk),
        .nrst (nrst),
        .tick (mfTick)
    );

    // Reserved clock sources give no time base
    assign tick = (srcUsed == SRC_LF) ? lfTick :                            // RULE_01
                  (srcUsed == SRC_MF) ? mfTick : 1'b0;                      // RULE_01

    always_comb begin
        case (cfgWord.mode)
            MODE_ON:    active = 1'b1;
            MODE_AWAKE: active = !sleepMode;
            MODE_SOFT:  active = swEnable_reg;
            default:    active = 1'b0;
        endcase
    end

    // Window delay in eighths of the period: (7 - code) closed eighths
    assign windowed   = (spanUsed != CODE_FREE);                            // RULE_17
    assign closed     = windowed && ({3'b000, count, 3'b000} <              // RULE_02
                        (29'(CODE_FREE - spanUsed) << periodShift(periodUsed)));
    assign violation  = active && clearReq && windowed
                        && (closed || !armed_reg);                          // RULE_12 RULE_13
    assign validClear = active && clearReq && !violation;
    assign ctrlWrite  = wrAcc && (paddr == OFS_CTRL0 || paddr == OFS_CTRL1);
    assign cntClear   = !active || validClear || violation || ctrlWrite;    // RULE_14

    wdt_count_unit counter (
        .mclk    (mclk),
        .nrst    (nrst),
        .tick    (tick && active),
        .clear   (cntClear),
        .period  (periodUsed),
        .count   (count),
        .timeout (timeout)
    );

    // Arming read wins over a clear in the same cycle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            armed_reg <= 1'b0;
        end else if (rdAcc && paddr == OFS_CTRL0) begin
            armed_reg <= 1'b1;                                              // RULE_13
        end else if (cntClear) begin
            armed_reg <= 1'b0;                                              // RULE_16
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            resetReq    <= 1'b0;
            spanViolate <= 1'b0;
        end else begin
            resetReq    <= violation || (timeout && !sleepMode);            // RULE_12
            spanViolate <= violation;                                       // RULE_12
        end
    end

    // ------------------------------------------------------------
    // Event status and interrupt
    // ------------------------------------------------------------
    logic [NUM_EVT-1:0] evtStatus_reg;
    logic [NUM_EVT-1:0] evtEnable_reg;
    logic [NUM_EVT-1:0] evtSet;
    logic [NUM_EVT-1:0] evtClr;

    assign evtSet[EVT_TIMEOUT] = timeout;
    assign evtSet[EVT_SPAN]    = violation;
    assign evtClr = (wrAcc && paddr == OFS_EVT_CLR) ? pwdata[NUM_EVT-1:0] : '0;

    generate
        for (genvar i = 0; i < NUM_EVT; i++) begin : g_evt
            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    evtStatus_reg[i] <= 1'b0;
                end else if (evtSet[i]) begin
                    evtStatus_reg[i] <= 1'b1;
                end else if (evtClr[i]) begin
                    evtStatus_reg[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            evtEnable_reg <= '0;
        end else if (wrAcc && paddr == OFS_EVT_EN) begin
            evtEnable_reg <= pwdata[NUM_EVT-1:0];
        end
    end

    assign irq = |(evtStatus_reg & evtEnable_reg);

    // ------------------------------------------------------------
    // Read data, captured in the setup cycle
    // ------------------------------------------------------------
    logic [7:0] rdByte;

    always_comb begin
        rdByte = 8'h00;                                                     // RULE_11
        case (paddr)
            OFS_CTRL0: begin
                rdByte[PERIOD_POS +: 5] = periodUsed;
                rdByte[SWEN_POS]        = swEnable_reg;
            end
            OFS_CTRL1: begin
                rdByte[SRC_POS +: 3]  = srcUsed;                            // RULE_01
                rdByte[SPAN_POS +: 3] = spanUsed;                           // RULE_02
            end
            OFS_PS_LOW:  rdByte = count[7:0];                               // RULE_07
            OFS_PS_HIGH: rdByte = count[15:8];                              // RULE_07
            OFS_TIMER: begin
                rdByte[1:0]         = count[PS_W-1:16];                     // RULE_07
                rdByte[ARM_POS]     = armed_reg;                            // RULE_10
                rdByte[WCNT_POS +: 4] = count[PS_W +: 4];                   // RULE_09
            end
            OFS_EVT_ST: rdByte[NUM_EVT-1:0] = evtStatus_reg;
            OFS_EVT_EN: rdByte[NUM_EVT-1:0] = evtEnable_reg;
            default:    rdByte = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (setupPhase) begin
            prdata  <= {24'h000000, rdByte};
            pslverr <= !mapped(paddr);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    chk_open_no_violate: assert property (                                  // RULE_17
        (clearReq && spanUsed == CODE_FREE) |=> !spanViolate)
        else $error("violation with fully open window");
    chk_unarmed_violate: assert property (                                  // RULE_13
        (active && clearReq && windowed && !armed_reg) |=> spanViolate && resetReq)
        else $error("unarmed clear did not violate");
    chk_closed_violate: assert property (                                   // RULE_12
        (active && clearReq && closed) |=> resetReq && spanViolate)
        else $error("closed window clear did not reset");
    chk_write_clears: assert property (ctrlWrite |=> count == '0 && !timeout) // RULE_14
        else $error("control write did not clear counter");
    chk_arm_drop: assert property (                                         // RULE_16
        (cntClear && !(rdAcc && paddr == OFS_CTRL0)) |=> !armed_reg)
        else $error("armed state kept after clear");
    chk_src_locked: assert property (                                       // RULE_05
        (loaded_reg && !srcFree) |=> $stable(source_reg))
        else $error("locked clock source changed");
    chk_span_locked: assert property (                                      // RULE_06
        (loaded_reg && !spanFree) |=> $stable(span_reg))
        else $error("locked window field changed");
    chk_timer_read: assert property (                                       // RULE_09
        (setupPhase && paddr == OFS_TIMER) |=>
        prdata[7] == 1'b0 && prdata[ARM_POS] == $past(armed_reg)
        && prdata[WCNT_POS +: 4] == $past(count[PS_W +: 4]))
        else $error("timer register readback wrong");
    chk_ctrl1_zero: assert property (                                       // RULE_11
        (setupPhase && paddr == OFS_CTRL1) |=> prdata[7] == 1'b0 && prdata[3] == 1'b0)
        else $error("unimplemented control bits not zero");
    chk_reserved_src: assert property (                                     // RULE_01
        (srcUsed > SRC_MF) |-> !tick)
        else $error("reserved clock source ticks");

    cov_valid_clear: cover property (validClear && windowed);
    cov_violation:   cover property (violation && armed_reg);
    cov_timeout:     cover property (timeout);
    cov_irq:         cover property (irq ##1 !irq);

endmodule
`default_nettype wire

// File: inc/wdt_pkg.sv
// Shared constants, codes and carriers of the windowed watchdog register block
package wdt_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int MCLK_HZ        = 100_000_000;
    localparam int LF_OSC_HZ      = 31_000;
    localparam int MF_OSC_HZ      = 31_250;
    localparam int LF_TICK_CYCLES = MCLK_HZ / LF_OSC_HZ;
    localparam int MF_TICK_CYCLES = MCLK_HZ / MF_OSC_HZ;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL0   = 8'h00;
    localparam logic [7:0] OFS_CTRL1   = 8'h04;
    localparam logic [7:0] OFS_PS_LOW  = 8'h08;
    localparam logic [7:0] OFS_PS_HIGH = 8'h0c;
    localparam logic [7:0] OFS_TIMER   = 8'h10;
    localparam logic [7:0] OFS_EVT_ST  = 8'h14;
    localparam logic [7:0] OFS_EVT_EN  = 8'h18;
    localparam logic [7:0] OFS_EVT_CLR = 8'h1c;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SWEN_POS   = 0;
    localparam int PERIOD_POS = 1;
    localparam int SRC_POS    = 4;
    localparam int SPAN_POS   = 0;
    localparam int ARM_POS    = 2;
    localparam int WCNT_POS   = 3;
    localparam int PS_W       = 18;
    localparam int TOT_W      = 23;
    localparam int EVT_TIMEOUT = 0;
    localparam int EVT_SPAN    = 1;
    localparam int NUM_EVT     = 2;

    // ------------------------------------------------------------
    // Codes and reset values
    // ------------------------------------------------------------
    localparam logic [2:0] CODE_FREE      = 3'h7;
    localparam logic [2:0] SRC_LF         = 3'h0;
    localparam logic [2:0] SRC_MF         = 3'h1;
    localparam logic [4:0] PERIOD_FREE    = 5'h1f;
    localparam logic [4:0] PERIOD_DEFAULT = 5'h0b;
    localparam logic [4:0] PERIOD_MAX     = 5'h12;
    localparam logic [4:0] MIN_SHIFT      = 5'h05;
    localparam logic [1:0] MODE_ON        = 2'h3;
    localparam logic [1:0] MODE_AWAKE     = 2'h2;
    localparam logic [1:0] MODE_SOFT      = 2'h1;

    // Configuration word fields seen by the watchdog
    typedef struct packed {
        logic [1:0] mode;
        logic [2:0] clockSource;
        logic [4:0] period;
        logic [2:0] openSpan;
    } cfg_word_type;

    // Period code to power of two of the full period
    function automatic logic [4:0] periodShift(input logic [4:0] code);
        periodShift = (code > PERIOD_MAX) ? MIN_SHIFT : 5'(code + MIN_SHIFT);
    endfunction

endpackage

// File: rtl/tick_divider.sv
// One-cycle enable pulse at a divided rate of mclk
`timescale 1ns/10ps
`default_nettype none
module tick_divider #(
    parameter int DIV = 4
) (
    input  wire logic mclk,  // System clock
    input  wire logic nrst,  // Async reset, active low
    output logic      tick   // One pulse every DIV cycles
);
    localparam int W = $clog2(DIV);
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] cnt_reg;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= '0;
            tick    <= 1'b0;
        end else begin
            tick    <= (cnt_reg == LAST);
            cnt_reg <= (cnt_reg == LAST) ? '0 : cnt_reg + 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: rtl/wdt_count_unit.sv
// Prescale and watchdog counter chain with time-out detection
`timescale 1ns/10ps
`default_nettype none
module wdt_count_unit
    import wdt_pkg::*;
(
    input  wire logic             mclk,      // System clock
    input  wire logic             nrst,      // Async reset, active low
    input  wire logic             tick,      // Time base enable
    input  wire logic             clear,     // Clear counter
    input  wire logic [4:0]       period,    // Active period code
    output logic      [TOT_W-1:0] count,     // Prescale and counter value
    output logic                  timeout    // One-cycle time-out pulse
);
    logic [TOT_W-1:0] limit;

    assign limit = TOT_W'((24'h1 << periodShift(period)) - 24'h1);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            count   <= '0;
            timeout <= 1'b0;
        end else if (clear) begin
            count   <= '0;
            timeout <= 1'b0;
        end else begin
            timeout <= tick && (count >= limit);
            if (tick) begin
                count <= (count >= limit) ? '0 : count + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// File: bench/fw_model.sv
// Firmware model: APB register master and clear instruction source
`timescale 1ns/10ps
`default_nettype none
module fw_model
    import wdt_pkg::*;
(
    input  wire logic        mclk,     // System clock
    input  wire logic        pready,   // APB ready
    input  wire logic [31:0] prdata,   // APB read data
    input  wire logic        pslverr,  // APB error
    output var logic         psel,     // APB select
    output var logic         penable,  // APB enable
    output var logic         pwrite,   // APB direction
    output var logic  [7:0]  paddr,    // APB byte address
    output var logic  [31:0] pwdata,   // APB write data
    output var logic         clearReq  // Clear instruction pulse
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        clearReq = 1'b0;
    end

    // One transfer, entered just after a rising edge; request held until pready
    task automatic access(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                          output logic [31:0] rdata, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~addr;
        pwdata <= ~wdata;
        @(posedge mclk);
    endtask

    // Clear instruction, optionally preceded by the arming read
    task automatic clearWdt(input logic arm);
        logic [31:0] d;
        logic        e;
        if (arm) begin
            access(1'b0, OFS_CTRL0, 32'h0, d, e);
        end
        clearReq <= 1'b1;
        @(posedge mclk);
        clearReq <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask

    // Timing kept by cycle count, never by prescale readback
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// File: bench/tb_wdt_config_readback.sv
// Self-checking bench of the watchdog register block
`timescale 1ns/10ps
`default_nettype none
module tb_wdt_config_readback
    import wdt_pkg::*;
;
    logic         mclk;
    logic         nrst;
    cfg_word_type cfgWord;
    logic         sleepMode;
    logic         clearReq, psel, penable, pwrite, pready, pslverr;
    logic [7:0]   paddr;
    logic [31:0]  pwdata, prdata, v;
    logic         resetReq, spanViolate, irq, e;
    int           errCount, nCompared, vioCnt, rstCnt, cycles;

    wdt_config_readback dut (.mclk(mclk), .nrst(nrst), .cfgWord(cfgWord),
        .sleepMode(sleepMode), .clearReq(clearReq), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .resetReq(resetReq),
        .spanViolate(spanViolate), .irq(irq));

    fw_model fw (.mclk(mclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .clearReq(clearReq));

    always #5 mclk = ~mclk;

    // ------------------------------------------------------------
    // Pulse counters and hang guard
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        cycles++;
        if (spanViolate === 1'b1) vioCnt++;
        if (resetReq === 1'b1) rstCnt++;
        if (cycles == 40000) begin
            errCount++;
            giveVerdict();
        end
    end

    task automatic giveVerdict();
        $display("compared %0d, mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errCount++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic x;
        fw.access(1'b0, a, 32'h0, r, x);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        rd(a, r);
        check(r, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        x;
        fw.access(1'b1, a, d, r, x);
    endtask

    task automatic doReset();
        nrst <= 1'b0;
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        repeat (2) @(posedge mclk);
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        nrst = 1'b0;
        sleepMode = 1'b0;
        {errCount, nCompared, vioCnt, rstCnt, cycles} = '0;
        cfgWord = '{mode: MODE_ON, clockSource: CODE_FREE, period: PERIOD_DEFAULT,
                    openSpan: CODE_FREE};
        @(posedge mclk);
        doReset();
        rdChk(OFS_CTRL1, 32'h07);
        rdChk(OFS_PS_LOW, 32'h00);
        rdChk(OFS_PS_HIGH, 32'h00);
        rdChk(OFS_TIMER, 32'h00);
        wr(OFS_CTRL1, 32'hff);
        rdChk(OFS_CTRL1, 32'h77);
        $display("test defaults done");
        for (int c = 0; c < 8; c++) begin
            wr(OFS_CTRL1, {25'h0, c[2:0], 4'h7});
            rdChk(OFS_CTRL1, {25'h0, c[2:0], 4'h7});
            fw.idle(3500);
            rd(OFS_PS_LOW, v);
            check(32'((c < 2) ? (v == 32'h1 || v == 32'h2) : (v == 32'h0)), 32'h1);
        end
        $display("test clock source done");
        fw.clearWdt(1'b0);
        check(32'(vioCnt), 32'h0);
        rdChk(OFS_CTRL0, 32'h16);
        rdChk(OFS_TIMER, 32'h04);
        fw.clearWdt(1'b0);
        rdChk(OFS_TIMER, 32'h00);
        rdChk(OFS_CTRL0, 32'h16);
        wr(OFS_CTRL0, 32'h00);
        rdChk(OFS_TIMER, 32'h00);
        check(32'(vioCnt), 32'h0);
        $display("test arming done");
        cfgWord <= '{mode: MODE_ON, clockSource: SRC_MF, period: PERIOD_DEFAULT,
                     openSpan: 3'h5};
        doReset();
        rdChk(OFS_CTRL1, 32'h15);
        wr(OFS_CTRL1, 32'h00);
        rdChk(OFS_CTRL1, 32'h15);
        wr(OFS_EVT_EN, 32'h02);
        fw.clearWdt(1'b0);
        check(32'(vioCnt), 32'h1);
        check(32'(rstCnt), 32'h1);
        check({31'h0, irq}, 32'h1);
        fw.clearWdt(1'b1);
        check(32'(vioCnt), 32'h2);
        rdChk(OFS_EVT_ST, 32'h02);
        wr(OFS_EVT_EN, 32'h00);
        check({31'h0, irq}, 32'h0);
        wr(OFS_EVT_EN, 32'h02);
        check({31'h0, irq}, 32'h1);
        wr(OFS_EVT_CLR, 32'h02);
        rdChk(OFS_EVT_ST, 32'h00);
        check({31'h0, irq}, 32'h0);
        fw.access(1'b0, 8'h20, 32'h0, v, e);
        check({31'h0, e}, 32'h1);
        check(v, 32'h0);
        $display("test window and events done");
        cfgWord <= '{mode: MODE_SOFT, clockSource: SRC_LF, period: PERIOD_FREE,
                     openSpan: 3'h0};
        doReset();
        rdChk(OFS_CTRL0, 32'h16);
        fw.clearWdt(1'b0);
        check(32'(vioCnt), 32'h2);
        wr(OFS_CTRL0, 32'h07);
        rdChk(OFS_CTRL0, 32'h07);
        fw.clearWdt(1'b0);
        check(32'(vioCnt), 32'h3);
        check(32'(rstCnt), 32'h3);
        cfgWord <= '{mode: MODE_AWAKE, clockSource: SRC_LF, period: PERIOD_DEFAULT,
                     openSpan: 3'h0};
        sleepMode <= 1'b1;
        doReset();
        fw.clearWdt(1'b0);
        check(32'(vioCnt), 32'h3);
        sleepMode <= 1'b0;
        fw.clearWdt(1'b0);
        check(32'(vioCnt), 32'h4);
        $display("test enable modes done");
        giveVerdict();
    end
endmodule
`default_nettype wire
